/* File: hdl/asp_pkg.sv */
// Constants, register map and state record of the serial port
package asp_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [11:0] OFF_DATA = 12'h000;
    localparam logic [11:0] OFF_RSR = 12'h004;
    localparam logic [11:0] OFF_FLAG = 12'h018;
    localparam logic [11:0] OFF_ILP = 12'h020;
    localparam logic [11:0] OFF_IBRD = 12'h024;
    localparam logic [11:0] OFF_FBRD = 12'h028;
    localparam logic [11:0] OFF_LCR = 12'h02C;
    localparam logic [11:0] OFF_CTL = 12'h030;
    localparam logic [11:0] OFF_IFLS = 12'h034;
    localparam logic [11:0] OFF_IM = 12'h038;
    localparam logic [11:0] OFF_RIS = 12'h03C;
    localparam logic [11:0] OFF_MIS = 12'h040;
    localparam logic [11:0] OFF_ICR = 12'h044;
    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int LCR_PEN = 1;
    localparam int LCR_EPS = 2;
    localparam int LCR_STP2 = 3;
    localparam int LCR_FEN = 4;
    localparam int LCR_WLEN = 5;
    localparam int CTL_EN = 0;
    localparam int CTL_SIR = 1;
    localparam int CTL_LP = 2;
    localparam int CTL_LBE = 7;
    localparam int CTL_TXE = 8;
    localparam int CTL_RXE = 9;
    localparam int FR_BUSY = 3;
    localparam int FR_RX_EMPTY_FLAG = 4;
    localparam int FR_TX_FULL_FLAG = 5;
    localparam int FR_RX_FULL_FLAG = 6;
    localparam int FR_TX_EMPTY_FLAG = 7;
    localparam int INT_RX = 4;
    localparam int INT_TX = 5;
    localparam int INT_RT = 6;
    localparam int INT_FE = 7;
    localparam int INT_PE = 8;
    localparam int INT_BE = 9;
    localparam int INT_OE = 10;
    // ****************************************************************
    // Reset values and counts
    // ****************************************************************
    localparam logic [9:0] CTL_RST = 10'h300;
    localparam logic [5:0] IFLS_RST = 6'h12;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [3:0] START_TICK = 4'h7;
    localparam logic [3:0] BIT_TICK = 4'hF;
    localparam logic [3:0] IR_NORM = 4'h3;
    localparam logic [1:0] IR_LP = 2'h3;
    localparam logic [4:0] IR_HOLD = 5'h10;
    localparam int RT_BITS = 32;
    localparam logic [9:0] RT_TICKS = 10'(RT_BITS * 16);
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
        TX_PAR = 5'h08, TX_STOP = 5'h10} asp_tx_e;
    typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
        RX_PAR = 5'h08, RX_STOP = 5'h10} asp_rx_e;
    typedef struct packed {
        asp_tx_e txs;
        asp_rx_e rxs;
        logic sin1, sin2;
        logic [15:0] ibrd_sh, ibrd, bcnt;
        logic [5:0] fbrd_sh, fbrd, facc, ifls;
        logic [7:0] lcr, ilpr, lpcnt;
        logic [9:0] ctl, rtcnt;
        logic [10:0] im, ris;
        logic [3:0] rsr;
        logic tick, lptick;
        logic [15:0][7:0] txf;
        logic [3:0] txw, txr, txsub, rxw, rxr, rxsub;
        logic [4:0] txc, rxc, irhold;
        logic [15:0][11:0] rxf;
        logic oe_pend, txpar, stop2, txd, rxpar, rxprev;
        logic [2:0] txbit, rxbit;
        logic [7:0] txsh, rxsh;
        logic [1:0] irlp;
        logic sout, intr;
        logic [31:0] rdata;
    } asp_state_s;
    localparam asp_state_s ST_RST = '{txs: TX_IDLE, rxs: RX_IDLE, ctl: CTL_RST,
        ifls: IFLS_RST, txd: 1'b1, rxprev: 1'b1, sout: 1'b1, default: '0};
endpackage

/* File: hdl/asp_uart.sv */
// Serial port with FIFOs, interrupt combining and infrared codec
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module asp_uart (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Register port
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Serial line
    input wire logic SIN,
    output logic SOUT,
    // Interrupt request
    output logic INTR
);
    // ****************************************************************
    // Decoders
    // ****************************************************************
    function automatic logic [7:0] wmask(input logic [1:0] wl);
        wmask = 8'hFF >> (2'h3 - wl);
    endfunction
    function automatic logic [4:0] level(input logic [2:0] sel);
        case (sel)
            3'h0: level = 5'h02;
            3'h1: level = 5'h04;
            3'h3: level = 5'h0C;
            3'h4: level = 5'h0E;
            default: level = 5'h08;
        endcase
    endfunction

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_r;
    logic rst_n;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_r <= 2'h0;
        end else begin
            rst_r <= {rst_r[0], 1'b1};
        end
    end
    assign rst_n = rst_r[1];

    // ****************************************************************
    // State and next state
    // ****************************************************************
    asp_pkg::asp_state_s q_r, d_nxt;
    logic en, sir, fifo_enable_bit, pen, eps, carry, line, busy, fe, pe, be;
    logic tx_push, tx_pop, rx_push, rx_in, rx_pop;
    logic [2:0] nbm1;
    logic [4:0] depth, rxthr, txthr, rxc_new, txc_new;
    logic [7:0] rxdat;
    logic [10:0] ev, clr;
    logic [11:0] rent;
    logic [31:0] rmux, fr;

    always_comb begin
        d_nxt = q_r;
        ev = 11'h0;
        clr = 11'h0;
        carry = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_in = 1'b0;
        rx_pop = 1'b0;
        rmux = 32'h0;
        fr = 32'h0;
        en = q_r.ctl[asp_pkg::CTL_EN];
        sir = q_r.ctl[asp_pkg::CTL_SIR];
        fifo_enable_bit = q_r.lcr[asp_pkg::LCR_FEN];
        pen = q_r.lcr[asp_pkg::LCR_PEN];
        eps = q_r.lcr[asp_pkg::LCR_EPS];
        nbm1 = {1'b1, q_r.lcr[asp_pkg::LCR_WLEN +: 2]};
        depth = fifo_enable_bit ? asp_pkg::FIFO_DEPTH : 5'h01;
        busy = (q_r.txc != 5'h0) || (q_r.txs != asp_pkg::TX_IDLE);
        rent = q_r.rxf[q_r.rxr];
        // Pin synchroniser
        d_nxt.sin1 = SIN;
        d_nxt.sin2 = q_r.sin1;
        // Oversample tick from integer and fractional divisor
        d_nxt.tick = 1'b0;
        if (q_r.ibrd != 16'h0) begin
            if (q_r.bcnt == 16'h0) begin
                d_nxt.tick = 1'b1;
                {carry, d_nxt.facc} = {1'b0, q_r.facc} + {1'b0, q_r.fbrd};
                d_nxt.bcnt = q_r.ibrd - 16'h1 + {15'h0, carry};
            end else begin
                d_nxt.bcnt = q_r.bcnt - 16'h1;
            end
        end
        d_nxt.lptick = 1'b0;
        if (q_r.ilpr != 8'h0) begin
            if (q_r.lpcnt == 8'h0) begin
                d_nxt.lptick = 1'b1;
                d_nxt.lpcnt = q_r.ilpr - 8'h1;
            end else begin
                d_nxt.lpcnt = q_r.lpcnt - 8'h1;
            end
        end
        // Receive line source
        if (sir && !q_r.sin2) begin
            d_nxt.irhold = asp_pkg::IR_HOLD;
        end else if (q_r.tick && q_r.irhold != 5'h0) begin
            d_nxt.irhold = q_r.irhold - 5'h1;
        end
        if (q_r.ctl[asp_pkg::CTL_LBE]) begin
            line = q_r.txd;
        end else if (sir) begin
            line = (q_r.irhold == 5'h0) || (q_r.txs != asp_pkg::TX_IDLE);
        end else begin
            line = q_r.sin2;
        end
        rxdat = q_r.rxsh >> (3'h7 - nbm1);
        fe = !line;
        pe = pen && (q_r.rxpar != (^rxdat ^ !eps));
        be = (rxdat == 8'h0) && !line && (!pen || !q_r.rxpar);
        // Register writes
        if (WR) begin
            case (ADDR)
                asp_pkg::OFF_DATA: begin
                    if (q_r.txc < depth) begin
                        d_nxt.txf[q_r.txw] = WDATA[7:0];
                        d_nxt.txw = q_r.txw + 4'h1;
                        tx_push = 1'b1;
                    end
                end
                asp_pkg::OFF_RSR: d_nxt.rsr = 4'h0;
                asp_pkg::OFF_ILP: d_nxt.ilpr = WDATA[7:0];
                asp_pkg::OFF_IBRD: d_nxt.ibrd_sh = WDATA[15:0];
                asp_pkg::OFF_FBRD: d_nxt.fbrd_sh = WDATA[5:0];
                asp_pkg::OFF_LCR: begin
                    d_nxt.lcr = WDATA[7:0];
                    d_nxt.ibrd = q_r.ibrd_sh;
                    d_nxt.fbrd = q_r.fbrd_sh;
                end
                asp_pkg::OFF_CTL: d_nxt.ctl = WDATA[9:0];
                asp_pkg::OFF_IFLS: d_nxt.ifls = WDATA[5:0];
                asp_pkg::OFF_IM: d_nxt.im = WDATA[10:0];
                asp_pkg::OFF_ICR: clr = WDATA[10:0];
                default: ;
            endcase
        end
        // Register reads
        fr[asp_pkg::FR_BUSY] = busy;
        fr[asp_pkg::FR_RX_EMPTY_FLAG] = (q_r.rxc == 5'h0);
        fr[asp_pkg::FR_TX_FULL_FLAG] = (q_r.txc >= depth);
        fr[asp_pkg::FR_RX_FULL_FLAG] = (q_r.rxc >= depth);
        fr[asp_pkg::FR_TX_EMPTY_FLAG] = (q_r.txc == 5'h0);
        if (RD) begin
            case (ADDR)
                asp_pkg::OFF_DATA: begin
                    rmux = {20'h0, rent};
                    if (q_r.rxc != 5'h0) begin
                        rx_pop = 1'b1;
                        d_nxt.rxr = q_r.rxr + 4'h1;
                        d_nxt.rsr[2:0] = q_r.rsr[2:0] | rent[10:8];
                    end
                end
                asp_pkg::OFF_RSR: rmux = {28'h0, q_r.rsr};
                asp_pkg::OFF_FLAG: rmux = fr;
                asp_pkg::OFF_ILP: rmux = {24'h0, q_r.ilpr};
                asp_pkg::OFF_IBRD: rmux = {16'h0, q_r.ibrd_sh};
                asp_pkg::OFF_FBRD: rmux = {26'h0, q_r.fbrd_sh};
                asp_pkg::OFF_LCR: rmux = {24'h0, q_r.lcr};
                asp_pkg::OFF_CTL: rmux = {22'h0, q_r.ctl};
                asp_pkg::OFF_IFLS: rmux = {26'h0, q_r.ifls};
                asp_pkg::OFF_IM: rmux = {21'h0, q_r.im};
                asp_pkg::OFF_RIS: rmux = {21'h0, q_r.ris};
                asp_pkg::OFF_MIS: rmux = {21'h0, q_r.ris & q_r.im};
                default: rmux = 32'h0;
            endcase
        end
        d_nxt.rdata = rmux;
        // Transmitter
        if (q_r.lptick && q_r.irlp != 2'h0) begin
            d_nxt.irlp = q_r.irlp - 2'h1;
        end
        if (q_r.tick) begin
            if (q_r.txs == asp_pkg::TX_IDLE) begin
                if (q_r.txc != 5'h0 && en && q_r.ctl[asp_pkg::CTL_TXE]) begin
                    tx_pop = 1'b1;
                    d_nxt.txsh = q_r.txf[q_r.txr];
                    d_nxt.txr = q_r.txr + 4'h1;
                    d_nxt.txpar = ^(q_r.txf[q_r.txr] & wmask(nbm1[1:0])) ^ !eps;
                    d_nxt.txs = asp_pkg::TX_START;
                    d_nxt.txsub = 4'h0;
                    d_nxt.txd = 1'b0;
                    d_nxt.irlp = asp_pkg::IR_LP;
                end
            end else if (q_r.txsub != asp_pkg::BIT_TICK) begin
                d_nxt.txsub = q_r.txsub + 4'h1;
            end else begin
                d_nxt.txsub = 4'h0;
                d_nxt.irlp = asp_pkg::IR_LP;
                unique case (q_r.txs)
                    asp_pkg::TX_START: begin
                        d_nxt.txs = asp_pkg::TX_DATA;
                        d_nxt.txbit = 3'h0;
                        d_nxt.txd = q_r.txsh[0];
                    end
                    asp_pkg::TX_DATA: begin
                        if (q_r.txbit == nbm1) begin
                            d_nxt.txs = pen ? asp_pkg::TX_PAR : asp_pkg::TX_STOP;
                            d_nxt.txd = pen ? q_r.txpar : 1'b1;
                            d_nxt.stop2 = q_r.lcr[asp_pkg::LCR_STP2];
                        end else begin
                            d_nxt.txbit = q_r.txbit + 3'h1;
                            d_nxt.txsh = q_r.txsh >> 1;
                            d_nxt.txd = q_r.txsh[1];
                        end
                    end
                    asp_pkg::TX_PAR: begin
                        d_nxt.txs = asp_pkg::TX_STOP;
                        d_nxt.txd = 1'b1;
                    end
                    asp_pkg::TX_STOP: begin
                        if (q_r.stop2) begin
                            d_nxt.stop2 = 1'b0;
                        end else begin
                            d_nxt.txs = asp_pkg::TX_IDLE;
                        end
                    end
                    default: d_nxt.txs = asp_pkg::TX_IDLE;
                endcase
            end
        end
        // Pin drive: uart level, or infrared pulses on zero bits
        if (q_r.ctl[asp_pkg::CTL_LBE]) begin
            d_nxt.sout = !sir;
        end else if (sir) begin
            d_nxt.sout = !q_r.txd && (q_r.txs != asp_pkg::TX_IDLE) &&
                (q_r.ctl[asp_pkg::CTL_LP] ? (q_r.irlp != 2'h0) :
                (q_r.txsub < asp_pkg::IR_NORM));
        end else begin
            d_nxt.sout = q_r.txd;
        end
        // Receiver
        if (q_r.tick) begin
            d_nxt.rxprev = line;
            if (q_r.rxs == asp_pkg::RX_IDLE) begin
                if (q_r.rxprev && !line && en && q_r.ctl[asp_pkg::CTL_RXE]) begin
                    d_nxt.rxs = asp_pkg::RX_START;
                    d_nxt.rxsub = 4'h1;
                end
            end else if (q_r.rxsub != ((q_r.rxs == asp_pkg::RX_START) ?
                    asp_pkg::START_TICK : asp_pkg::BIT_TICK)) begin
                d_nxt.rxsub = q_r.rxsub + 4'h1;
            end else begin
                d_nxt.rxsub = 4'h0;
                unique case (q_r.rxs)
                    asp_pkg::RX_START: begin
                        d_nxt.rxs = line ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
                        d_nxt.rxbit = 3'h0;
                    end
                    asp_pkg::RX_DATA: begin
                        d_nxt.rxsh = {line, q_r.rxsh[7:1]};
                        d_nxt.rxbit = q_r.rxbit + 3'h1;
                        if (q_r.rxbit == nbm1) begin
                            d_nxt.rxs = pen ? asp_pkg::RX_PAR : asp_pkg::RX_STOP;
                        end
                    end
                    asp_pkg::RX_PAR: begin
                        d_nxt.rxpar = line;
                        d_nxt.rxs = asp_pkg::RX_STOP;
                    end
                    asp_pkg::RX_STOP: begin
                        rx_push = 1'b1;
                        d_nxt.rxs = asp_pkg::RX_IDLE;
                    end
                    default: d_nxt.rxs = asp_pkg::RX_IDLE;
                endcase
            end
        end
        if (rx_push) begin
            ev[asp_pkg::INT_FE] = fe;
            ev[asp_pkg::INT_PE] = pe;
            ev[asp_pkg::INT_BE] = be;
            if (q_r.rxc >= depth) begin
                ev[asp_pkg::INT_OE] = 1'b1;
                d_nxt.rsr[3] = 1'b1;
                d_nxt.oe_pend = 1'b1;
            end else begin
                d_nxt.rxf[q_r.rxw] = {q_r.oe_pend, be, pe, fe, rxdat};
                d_nxt.rxw = q_r.rxw + 4'h1;
                d_nxt.oe_pend = 1'b0;
                rx_in = 1'b1;
            end
        end
        // Receive timeout
        if (rx_in || rx_pop || q_r.rxc == 5'h0 || q_r.rxs != asp_pkg::RX_IDLE) begin
            d_nxt.rtcnt = 10'h0;
        end else if (q_r.tick && q_r.rtcnt != asp_pkg::RT_TICKS) begin
            d_nxt.rtcnt = q_r.rtcnt + 10'h1;
            ev[asp_pkg::INT_RT] = (q_r.rtcnt == asp_pkg::RT_TICKS - 10'h1);
        end
        // FIFO counts and level events
        txc_new = q_r.txc + {4'h0, tx_push} - {4'h0, tx_pop};
        rxc_new = q_r.rxc + {4'h0, rx_in} - {4'h0, rx_pop};
        d_nxt.txc = txc_new;
        d_nxt.rxc = rxc_new;
        rxthr = fifo_enable_bit ? level(q_r.ifls[5:3]) : 5'h01;
        txthr = fifo_enable_bit ? level(q_r.ifls[2:0]) : 5'h00;
        ev[asp_pkg::INT_RX] = (rxc_new >= rxthr) && (q_r.rxc < rxthr);
        ev[asp_pkg::INT_TX] = (txc_new <= txthr) && (q_r.txc > txthr);
        // Sticky events, set beats clear
        d_nxt.ris = (q_r.ris & ~clr) | ev;
        d_nxt.intr = |(d_nxt.ris & d_nxt.im);
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= asp_pkg::ST_RST;
        end else begin
            q_r <= d_nxt;
        end
    end
    assign RDATA = q_r.rdata;
    assign SOUT = q_r.sout;
    assign INTR = q_r.intr;
    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!rst_n);
    a_tx_frame_start: assert property (
        q_r.tick && q_r.txs == asp_pkg::TX_IDLE && q_r.txc != 5'h0 && en &&
        q_r.ctl[asp_pkg::CTL_TXE] |=> q_r.txs == asp_pkg::TX_START && !q_r.txd)
        else $error("queued character did not start a frame");
    a_busy_release: assert property (
        $fell(busy) |-> q_r.txc == 5'h0 && $past(q_r.txs) == asp_pkg::TX_STOP)
        else $error("busy dropped before last stop bit");
    a_false_start: assert property (
        q_r.tick && q_r.rxs == asp_pkg::RX_START && q_r.rxsub == asp_pkg::START_TICK
        && line |=> q_r.rxs == asp_pkg::RX_IDLE)
        else $error("false start not rejected");
    a_rx_store: assert property (
        rx_push && q_r.rxc < depth && !rx_pop |=> q_r.rxc == $past(q_r.rxc) + 5'h1)
        else $error("received character not stored");
    a_ir_zero_pulse: assert property (
        sir && !q_r.ctl[asp_pkg::CTL_LBE] && !q_r.ctl[asp_pkg::CTL_LP] &&
        q_r.txs == asp_pkg::TX_START && q_r.txsub < asp_pkg::IR_NORM |=> SOUT)
        else $error("infrared zero pulse missing");
    a_ir_one_low: assert property (
        sir && q_r.txd |=> !SOUT)
        else $error("infrared one not low");
    a_intr_masked: assert property (
        INTR |-> |(q_r.ris & q_r.im))
        else $error("request raised without an enabled event");
    a_intr_level: assert property (
        |(q_r.ris & q_r.im) && !WR |=> INTR ##1 (INTR || $past(WR)))
        else $error("request not held while event set");
    a_divisor_latch: assert property (
        WR && ADDR == asp_pkg::OFF_LCR |=> q_r.ibrd == $past(q_r.ibrd_sh))
        else $error("divisor not latched by line control write");
    a_single_entry: assert property (
        !fifo_enable_bit && !$past(fifo_enable_bit) |-> q_r.txc <= 5'h1 && q_r.rxc <= 5'h1)
        else $error("holding register exceeded one entry");
endmodule // asp_uart
`default_nettype wire

/* File: tb/asp_remote_port.sv */
// Behavioural model of the remote serial port on the far side of the line
`timescale 1ns/100ps
`default_nettype none
module asp_remote_port #(
    parameter int BIT_NS = 800
) (
    // Line from the port
    input wire logic sout,
    // Line into the port
    output logic sin
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial sin = 1'b1;
    // ****************************************************************
    // Frame out: start, data LSB first, stop level chosen by caller
    // ****************************************************************
    task automatic send(input logic [7:0] d, input logic stop);
        #1; // Off the clock edge
        sin = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            sin = d[i];
            #(BIT_NS);
        end
        sin = stop;
        #(BIT_NS);
        sin = 1'b1;
    endtask
    // ****************************************************************
    // Frame in: mid-bit sampling after a confirmed start
    // ****************************************************************
    always @(negedge sout) begin
        #(BIT_NS / 2);
        if (sout === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                #(BIT_NS);
                sh[i] = sout;
            end
            rx_q.push_back(sh);
        end
    end
endmodule // asp_remote_port
`default_nettype wire

/* File: tb/asp_uart_test.sv */
// Self-checking bench for the serial port
`timescale 1ns/100ps
`default_nettype none
module asp_uart_test;
    logic mclk, resetn, wr, rd, sin, sout, intr;
    logic [11:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] b;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int ir_hi = 0;
    asp_uart dut_u (.MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SIN(sin), .SOUT(sout), .INTR(intr));
    asp_remote_port rp_u (.sout(sout), .sin(sin));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            test_done();
        end
    end
    always @(posedge mclk) begin
        if (sout === 1'b1) begin
            ir_hi = ir_hi + 1;
        end
    end
    // ****************************************************************
    // Register port and comparison tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] d;
        rreg(a, d);
        chk(n, e, d & m);
    endtask
    task automatic poll(input int bp, input logic v);
        logic [31:0] d;
        d = '0;
        d[bp] = ~v;
        for (int i = 0; i < 600 && d[bp] !== v; i++) begin
            rreg(asp_pkg::OFF_FLAG, d);
        end
        chk("flag wait", 32'(v), 32'(d[bp]));
    endtask
    function automatic int ir_width(input logic [7:0] d);
        return int'(asp_pkg::IR_NORM) * (9 - $countones(d));
    endfunction
    task automatic tx_cmp();
        poll(asp_pkg::FR_BUSY, 1'b0);
        chk("tx count", exp_q.size(), rp_u.rx_q.size());
        foreach (exp_q[i]) begin
            chk("tx byte", 32'(exp_q[i]), 32'(rp_u.rx_q[i]));
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {wr, rd, addr, wdata} = '0;
        resetn = 1'b0;
        void'($urandom(91081));
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        rchk("ctl", asp_pkg::OFF_CTL, 32'h3FF, 32'h300);
        rchk("ifls", asp_pkg::OFF_IFLS, 32'h3F, 32'h12);
        rchk("flags", asp_pkg::OFF_FLAG, 32'hF8, 32'h90);
        rchk("unmapped", 12'h008, 32'hFFFFFFFF, 32'h0);
        $display("reset test done");
        wreg(asp_pkg::OFF_CTL, 32'h300);
        wreg(asp_pkg::OFF_IBRD, 32'h1);
        wreg(asp_pkg::OFF_FBRD, 32'h0);
        wreg(asp_pkg::OFF_LCR, 32'h60);
        wreg(asp_pkg::OFF_DATA, 32'hA5);
        exp_q.push_back(8'hA5);
        rchk("one entry", asp_pkg::OFF_FLAG, 32'hF8, 32'h38);
        wreg(asp_pkg::OFF_CTL, 32'h301);
        wreg(asp_pkg::OFF_CTL, 32'h300);
        tx_cmp();
        wreg(asp_pkg::OFF_CTL, 32'h300);
        wreg(asp_pkg::OFF_LCR, 32'h70);
        wreg(asp_pkg::OFF_ICR, 32'h20);
        wreg(asp_pkg::OFF_IFLS, 32'h10);
        wreg(asp_pkg::OFF_CTL, 32'h301);
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            wreg(asp_pkg::OFF_DATA, {24'h0, b});
        end
        tx_cmp();
        rchk("ris tx", asp_pkg::OFF_RIS, 32'h20, 32'h20);
        $display("transmit test done");
        b = 8'($urandom);
        rp_u.send(b, 1'b1);
        poll(asp_pkg::FR_RX_EMPTY_FLAG, 1'b0);
        rchk("rx data", asp_pkg::OFF_DATA, 32'hFFF, {24'h0, b});
        wreg(asp_pkg::OFF_IM, 32'h80);
        b = 8'($urandom) | 8'h01; // Nonzero, so no break
        rp_u.send(b, 1'b0);
        poll(asp_pkg::FR_RX_EMPTY_FLAG, 1'b0);
        rchk("rx frame err", asp_pkg::OFF_DATA, 32'hFFF, {24'h1, b});
        rchk("ris fe", asp_pkg::OFF_RIS, 32'h80, 32'h80);
        chk("intr on", 32'h1, 32'(intr));
        wreg(asp_pkg::OFF_IM, 32'h0);
        rchk("ris masked", asp_pkg::OFF_RIS, 32'h80, 32'h80);
        chk("intr masked", 32'h0, 32'(intr));
        wreg(asp_pkg::OFF_IM, 32'h80);
        wreg(asp_pkg::OFF_ICR, 32'h80);
        rchk("ris clr", asp_pkg::OFF_RIS, 32'h80, 32'h0);
        rchk("mis clr", asp_pkg::OFF_MIS, 32'h80, 32'h0);
        chk("intr off", 32'h0, 32'(intr));
        $display("receive test done");
        wreg(asp_pkg::OFF_CTL, 32'h300);
        wreg(asp_pkg::OFF_LCR, 32'h60);
        wreg(asp_pkg::OFF_CTL, 32'h301);
        b = 8'($urandom);
        rp_u.send(b, 1'b1);
        rp_u.send(~b, 1'b1);
        repeat (600) @(posedge mclk);
        rchk("rsr oe", asp_pkg::OFF_RSR, 32'h8, 32'h8);
        rchk("ris oe rt", asp_pkg::OFF_RIS, 32'h440, 32'h440);
        rchk("kept data", asp_pkg::OFF_DATA, 32'hFF, {24'h0, b});
        $display("overrun test done");
        wreg(asp_pkg::OFF_CTL, 32'h381);
        b = 8'($urandom);
        wreg(asp_pkg::OFF_DATA, {24'h0, b});
        poll(asp_pkg::FR_RX_EMPTY_FLAG, 1'b0);
        rchk("loop data", asp_pkg::OFF_DATA, 32'hFF, {24'h0, b});
        tx_cmp();
        $display("loopback test done");
        wreg(asp_pkg::OFF_CTL, 32'h303);
        b = 8'($urandom);
        wreg(asp_pkg::OFF_DATA, {24'h0, b});
        ir_hi = 0;
        poll(asp_pkg::FR_BUSY, 1'b0);
        chk("ir pulses", 32'(ir_width(b)), 32'(ir_hi));
        $display("infrared test done");
        test_done();
    end
endmodule // asp_uart_test
`default_nettype wire
